/* File: logic/playfield_video_output.sv */
// Purpose: playfield back end: pointers, serialiser, palette, collisions
// Assumes: inputs synchronous to clk; wishbone master follows classic cycles
// Notes: plane and palette selection via adr index; one-cycle ack
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module playfield_video_output #(
    parameter int PLANES = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [video_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dma_write,
    input wire logic [2:0] dma_plane,
    input wire logic [15:0] dma_data,
    input wire logic line_end,
    input wire logic vertical_blank,
    input wire logic [7:0] sprite_pixels,
    input wire logic background_in,
    input wire logic genlock_audio_in,
    output video_pkg::rgb_t rgb_out,
    output logic background_output_pin,
    output video_pkg::mode_t mode_out,
    output logic [5:0] sprite_priority,
    output logic [video_pkg::PTR_W*6-1:0] plane_pointers
);
    // elaboration check: the register map only has room for six planes
    if (PLANES != video_pkg::NUM_PLANES) begin : bad_planes
        $error("only six planes are supported");
    end

    // ====================================================================
    // bus decode
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic [9:0] idx;
    logic [9:0] idx_off;
    logic [15:0] wdata;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
    assign bus_rd = bus_req && !wb_we_i;
    assign idx = wb_adr_i[11:2];
    assign wdata = wb_dat_i[15:0];

    // ====================================================================
    // control registers
    logic [15:0] main_ctrl, next_main_ctrl;
    logic [15:0] scroll_ctrl, next_scroll_ctrl;
    logic [15:0] prio_ctrl, next_prio_ctrl;
    logic [15:0] clx_ctrl, next_clx_ctrl;
    logic [15:0] odd_mod, next_odd_mod;
    logic [15:0] even_mod, next_even_mod;
    logic [video_pkg::PTR_W-1:0] ptr [6];
    logic [video_pkg::PTR_W-1:0] next_ptr [6];
    logic [15:0] plane_word [6];
    logic [15:0] next_plane_word [6];

    // plane number from index: pointers take pairs of words, data single words
    logic [2:0] ptr_plane;
    logic [2:0] dat_plane;
    logic ptr_hit_hi;
    logic ptr_hit_lo;
    logic dat_hit;
    always_comb begin
        idx_off = idx - video_pkg::IDX_PTR_HIGH;
        ptr_plane = idx_off[4:2];
        ptr_hit_hi = idx >= video_pkg::IDX_PTR_HIGH && idx_off[9:5] == 5'h00
            && idx_off[1:0] == 2'h0 && ptr_plane < 3'h6;
        ptr_hit_lo = idx >= video_pkg::IDX_PTR_HIGH && idx_off[9:5] == 5'h00
            && idx_off[1:0] == 2'h2 && ptr_plane < 3'h6;
        dat_plane = 3'((idx - video_pkg::IDX_DATA_WORD) >> 1);
        dat_hit = idx >= video_pkg::IDX_DATA_WORD && idx < 10'h11c && !idx[0];
    end

    // register writes, line-end modulo, dma loads
    always_comb begin
        next_main_ctrl = main_ctrl;
        next_scroll_ctrl = scroll_ctrl;
        next_prio_ctrl = prio_ctrl;
        next_clx_ctrl = clx_ctrl;
        next_odd_mod = odd_mod;
        next_even_mod = even_mod;
        for (int p = 0; p < 6; p++) begin
            next_ptr[p] = ptr[p];
            next_plane_word[p] = plane_word[p];
            // odd planes are 1,3,5 which are indexes 0,2,4
            if (line_end) begin
                next_ptr[p] = ptr[p] + 18'(p[0] ? {{2{even_mod[15]}}, even_mod}
                                               : {{2{odd_mod[15]}}, odd_mod});
            end
        end
        if (dma_write && dma_plane < 3'h6) begin
            next_plane_word[dma_plane] = dma_data;
        end
        if (bus_wr) begin
            case (idx)
                video_pkg::IDX_MAIN_CTRL: next_main_ctrl = wdata;
                video_pkg::IDX_SCROLL_CTRL: next_scroll_ctrl = wdata;
                video_pkg::IDX_PRIO_CTRL: next_prio_ctrl = wdata;
                video_pkg::IDX_CLX_CTRL: next_clx_ctrl = wdata;
                video_pkg::IDX_ODD_MOD: next_odd_mod = wdata;
                video_pkg::IDX_EVEN_MOD: next_even_mod = wdata;
                default: begin
                end
            endcase
            // processor write beats a same-cycle modulo add, so reloads stick
            if (ptr_hit_hi) begin
                next_ptr[ptr_plane][17:15] = wdata[2:0];
            end
            if (ptr_hit_lo) begin
                next_ptr[ptr_plane][14:0] = wdata[15:1];
            end
            if (dat_hit) begin
                next_plane_word[dat_plane] = wdata;
            end
        end
    end

    logic plane_one_load;
    assign plane_one_load = (dma_write && dma_plane == 3'h0)
        || (bus_wr && dat_hit && dat_plane == 3'h0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_ctrl <= video_pkg::CTRL_RESET;
            scroll_ctrl <= video_pkg::CTRL_RESET;
            prio_ctrl <= video_pkg::CTRL_RESET;
            clx_ctrl <= video_pkg::CTRL_RESET;
            odd_mod <= video_pkg::CTRL_RESET;
            even_mod <= video_pkg::CTRL_RESET;
            for (int p = 0; p < 6; p++) begin
                ptr[p] <= '0;
                plane_word[p] <= '0;
            end
        end else begin
            main_ctrl <= next_main_ctrl;
            scroll_ctrl <= next_scroll_ctrl;
            prio_ctrl <= next_prio_ctrl;
            clx_ctrl <= next_clx_ctrl;
            odd_mod <= next_odd_mod;
            even_mod <= next_even_mod;
            for (int p = 0; p < 6; p++) begin
                ptr[p] <= next_ptr[p];
                plane_word[p] <= next_plane_word[p];
            end
        end
    end

    // ====================================================================
    // serialiser: group loads on plane one, shifts msb first
    logic [15:0] shift [6];
    logic [15:0] next_shift [6];
    logic [3:0] bit_cnt, next_bit_cnt;
    logic shifting, next_shifting;
    logic [2:0] plane_count;
    logic [5:0] plane_mask;
    logic [5:0] raw_bits;
    assign plane_count = main_ctrl[video_pkg::MC_COUNT_HI:video_pkg::MC_COUNT_LO];
    always_comb begin
        for (int p = 0; p < 6; p++) begin
            // planes beyond the count read as zero; codes above six clamp
            plane_mask[p] = 3'(p) < plane_count;
            raw_bits[p] = shifting && shift[p][15] && plane_mask[p];
        end
    end

    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shifting = shifting;
        for (int p = 0; p < 6; p++) begin
            next_shift[p] = shifting ? {shift[p][14:0], 1'b0} : shift[p];
        end
        if (shifting) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == video_pkg::GROUP_LAST) begin
                next_shifting = 1'b0;
            end
        end
        if (plane_one_load) begin
            for (int p = 0; p < 6; p++) begin
                next_shift[p] = next_plane_word[p];
            end
            next_bit_cnt = '0;
            next_shifting = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= '0;
            shifting <= 1'b0;
            for (int p = 0; p < 6; p++) begin
                shift[p] <= '0;
            end
        end else begin
            bit_cnt <= next_bit_cnt;
            shifting <= next_shifting;
            for (int p = 0; p < 6; p++) begin
                shift[p] <= next_shift[p];
            end
        end
    end

    // ====================================================================
    // horizontal scroll: per-playfield delay line, code picks the tap
    logic [2:0] odd_hist [16];
    logic [2:0] even_hist [16];
    logic [2:0] odd_bits;
    logic [2:0] even_bits;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                odd_hist[i] <= '0;
                even_hist[i] <= '0;
            end
        end else begin
            odd_hist[0] <= {raw_bits[4], raw_bits[2], raw_bits[0]};
            even_hist[0] <= {raw_bits[5], raw_bits[3], raw_bits[1]};
            for (int i = 1; i < 16; i++) begin
                odd_hist[i] <= odd_hist[i-1];
                even_hist[i] <= even_hist[i-1];
            end
        end
    end
    // tap zero is the live bit, so code zero adds no delay
    always_comb begin
        odd_bits = scroll_ctrl[3:0] == 4'h0 ? {raw_bits[4], raw_bits[2], raw_bits[0]}
                                            : odd_hist[scroll_ctrl[3:0] - 4'h1];
        even_bits = scroll_ctrl[7:4] == 4'h0 ? {raw_bits[5], raw_bits[3], raw_bits[1]}
                                             : even_hist[scroll_ctrl[7:4] - 4'h1];
    end

    // ====================================================================
    // pixel index and palette
    logic [11:0] palette [video_pkg::NUM_COLOURS];
    logic [4:0] pal_idx;
    logic [4:0] pix_idx;
    logic odd_on;
    logic even_on;
    logic [5:0] pix_planes;
    // entries sit on every second index, so halve before cutting to five bits
    assign pal_idx = 5'((idx - video_pkg::IDX_PALETTE) >> 1);
    always_comb begin
        pix_planes = {even_bits[2], odd_bits[2], even_bits[1], odd_bits[1],
                      even_bits[0], odd_bits[0]};
        odd_on = |odd_bits;
        even_on = |even_bits;
        if (main_ctrl[video_pkg::MC_DUAL]) begin
            // dual playfield: front field wins, second field uses colours 8-15
            if (even_on && (prio_ctrl[video_pkg::PR_FRONT] || !odd_on)) begin
                pix_idx = {2'h1, even_bits};
            end else begin
                pix_idx = {2'h0, odd_bits};
            end
        end else begin
            pix_idx = pix_planes[4:0];
        end
    end

    always_ff @(posedge clk) begin
        if (bus_wr && idx >= video_pkg::IDX_PALETTE && idx < 10'h1c0 && !idx[0]) begin
            palette[pal_idx] <= wdata[11:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rgb_out <= '0;
            background_output_pin <= 1'b0;
            mode_out <= '0;
            sprite_priority <= '0;
        end else begin
            rgb_out <= palette[pix_idx];
            // genlock audio shares the background pin during vertical blank
            background_output_pin <= (main_ctrl[video_pkg::MC_GAUDIO] && vertical_blank)
                ? genlock_audio_in : (background_in || pix_idx == 5'h00);
            mode_out <= {main_ctrl[video_pkg::MC_HIGH_RESOLUTION_SELECT], main_ctrl[video_pkg::MC_HOLD],
                         main_ctrl[video_pkg::MC_COMPOSITE], main_ctrl[video_pkg::MC_GAUDIO],
                         main_ctrl[video_pkg::MC_LIGHT_PEN_ENABLE], main_ctrl[video_pkg::MC_INTERLACE_ENABLE],
                         main_ctrl[video_pkg::MC_RESYNC], main_ctrl[video_pkg::MC_DUAL]};
            sprite_priority <= prio_ctrl[5:0];
        end
    end

    always_comb begin
        for (int p = 0; p < 6; p++) begin
            plane_pointers[p*video_pkg::PTR_W +: video_pkg::PTR_W] = ptr[p];
        end
    end

    // ====================================================================
    // collision detection
    logic [3:0] spr;
    logic [5:0] match;
    logic pf1_hit;
    logic pf2_hit;
    logic [15:0] hits;
    logic [15:0] clx_flags, next_clx_flags;
    always_comb begin
        for (int s = 0; s < 4; s++) begin
            spr[s] = sprite_pixels[2*s] || (clx_ctrl[12+s] && sprite_pixels[2*s+1]);
        end
        for (int p = 0; p < 6; p++) begin
            // disabled or unused planes always match
            match[p] = !(clx_ctrl[6+p] && plane_mask[p])
                || (raw_bits[p] == clx_ctrl[p]);
        end
        pf1_hit = match[0] && match[2] && match[4];
        pf2_hit = match[1] && match[3] && match[5];
        hits = '0;
        hits[14] = spr[2] && spr[3];
        hits[13] = spr[1] && spr[3];
        hits[12] = spr[1] && spr[2];
        hits[11] = spr[0] && spr[3];
        hits[10] = spr[0] && spr[2];
        hits[9] = spr[0] && spr[1];
        for (int s = 0; s < 4; s++) begin
            hits[5+s] = pf2_hit && spr[s];
            hits[1+s] = pf1_hit && spr[s];
        end
        hits[0] = pf1_hit && pf2_hit;
        // a new hit in the read cycle survives the clear
        next_clx_flags = (bus_rd && idx == video_pkg::IDX_CLX_FLAGS)
            ? hits : (clx_flags | hits);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clx_flags <= '0;
        end else begin
            clx_flags <= next_clx_flags;
        end
    end

    // ====================================================================
    // bus answer: one wait-free ack, unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= '0;
            if (bus_rd && idx == video_pkg::IDX_CLX_FLAGS) begin
                wb_dat_o <= {16'h0000, clx_flags};
            end else if (bus_rd && idx == video_pkg::IDX_STATUS) begin
                wb_dat_o <= {27'h0, shifting, bit_cnt};
            end
        end
    end

    // ====================================================================
    // assertions
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_line_modulo: assert property (@(posedge clk) disable iff (rst)
        line_end && !bus_wr |=> ptr[0] == $past(ptr[0]) + 18'({{2{$past(odd_mod[15])}},
        $past(odd_mod)})) else $error("odd modulo not added");
    a_even_modulo: assert property (@(posedge clk) disable iff (rst)
        line_end && !bus_wr |=> ptr[1] == $past(ptr[1]) + 18'({{2{$past(even_mod[15])}},
        $past(even_mod)})) else $error("even modulo not added");
    a_group_start: assert property (@(posedge clk) disable iff (rst)
        plane_one_load |=> shifting && bit_cnt == 4'h0) else $error("group not started");
    sequence s_run16;
        shifting && bit_cnt == 4'hf;
    endsequence
    a_group_end: assert property (@(posedge clk) disable iff (rst)
        (s_run16 and !plane_one_load) |=> !shifting) else $error("group overran");
    a_msb_first: assert property (@(posedge clk) disable iff (rst)
        plane_one_load |=> shift[0][15] == $past(next_plane_word[0][15])) else $error("msb order");
    a_unused_zero: assert property (@(posedge clk) disable iff (rst)
        plane_count == 3'h0 |-> raw_bits == 6'h00) else $error("unused plane leaked");
    a_clear_on_read: assert property (@(posedge clk) disable iff (rst)
        bus_rd && idx == video_pkg::IDX_CLX_FLAGS |=> clx_flags == $past(hits)
        && wb_dat_o[15:0] == $past(clx_flags)) else $error("flags not cleared");
    a_all_disabled: assert property (@(posedge clk) disable iff (rst)
        clx_ctrl[11:6] == 6'h00 |-> pf1_hit && pf2_hit) else $error("disabled plane blocked");
    a_flag_unused: assert property (@(posedge clk) disable iff (rst)
        clx_flags[15] == 1'b0) else $error("bit 15 set");
    a_reset_modes: assert property (@(posedge clk)
        $fell(rst) |-> main_ctrl[3:1] == 3'h0) else $error("mode bits not cleared");
endmodule

/* File: logic/video_pkg.sv */
// Purpose: constants, register map and carriers for the playfield video back end
// Assumes: classic wishbone slave, 32-bit data, registers one per aligned word
// Notes: printed offsets are word indexes; byte address is four times the index
package video_pkg;
    localparam int NUM_PLANES = 6;
    localparam int NUM_COLOURS = 32;
    localparam int PTR_W = 18;
    localparam int PTR_HI_W = 3;
    localparam int PTR_LO_W = 15;
    localparam int ADDR_W = 12;
    // printed offsets kept as register indexes
    localparam logic [9:0] IDX_CLX_CTRL = 10'h098;
    localparam logic [9:0] IDX_PTR_HIGH = 10'h0e0;
    localparam logic [9:0] IDX_PTR_LOW = 10'h0e2;
    localparam logic [9:0] IDX_MAIN_CTRL = 10'h100;
    localparam logic [9:0] IDX_SCROLL_CTRL = 10'h102;
    localparam logic [9:0] IDX_PRIO_CTRL = 10'h104;
    localparam logic [9:0] IDX_ODD_MOD = 10'h108;
    localparam logic [9:0] IDX_EVEN_MOD = 10'h10a;
    localparam logic [9:0] IDX_DATA_WORD = 10'h110;
    localparam logic [9:0] IDX_PALETTE = 10'h180;
    localparam logic [9:0] IDX_CLX_FLAGS = 10'h00e;
    localparam logic [9:0] IDX_STATUS = 10'h010;
    // plane_main_control fields, then the priority front bit and shared constants
    localparam int MC_HIGH_RESOLUTION_SELECT = 15;
    localparam int MC_COUNT_HI = 14;
    localparam int MC_COUNT_LO = 12;
    localparam int MC_HOLD = 11;
    localparam int MC_DUAL = 10;
    localparam int MC_COMPOSITE = 9;
    localparam int MC_GAUDIO = 8;
    localparam int MC_LIGHT_PEN_ENABLE = 3;
    localparam int MC_INTERLACE_ENABLE = 2;
    localparam int MC_RESYNC = 1;
    localparam int PR_FRONT = 6;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [2:0] MAX_COUNT = 3'h6;
    localparam logic [3:0] GROUP_LAST = 4'hf;
    localparam logic [4:0] SCROLL_DEPTH = 5'h10;

    typedef struct packed {
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
    } rgb_t;

    typedef struct packed {
        logic high_resolution_select;
        logic hold_modify;
        logic composite;
        logic genlock_audio;
        logic light_pen;
        logic interlace;
        logic external_resync;
        logic dual_playfield;
    } mode_t;
endpackage

/* File: tb/plane_fetch_model.sv */
// Purpose: far-side model of the plane fetch channel feeding plane data words
// Assumes: one word per clock, pulse-qualified by dma_write
// Notes: plane one is sent only when last is set, and then last, because that load launches the group
`timescale 1ns/1ps
module plane_fetch_model (
    input wire logic clk,
    input wire logic go,
    input wire logic last,
    input wire logic [47:0] words,
    output logic dma_write,
    output logic [2:0] dma_plane,
    output logic [15:0] dma_data,
    output logic busy
);
    // ==========================================
    // fetch burst
    // planes go out top down; data bus shows garbage once released
    initial begin
        dma_write = 1'b0;
        dma_plane = 3'h0;
        dma_data = 16'h0000;
        busy = 1'b0;
    end
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (int p = 2; p >= 0; p--) begin
                if (p > 0 || last) begin
                    dma_write <= 1'b1;
                    dma_plane <= p[2:0];
                    dma_data <= words[p*16 +: 16];
                    @(posedge clk); // plane one last launches the group
                end
            end
            dma_write <= 1'b0;
            dma_data <= ~dma_data;
            busy <= 1'b0;
        end
    end
endmodule

/* File: tb/tb_playfield_video_output.sv */
// Purpose: self-checking bench for the playfield back end
// Assumes: one-cycle wishbone ack, one pixel per clock in high resolution
// Notes: bus reads and pixels are checked against queued expectations
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb_playfield_video_output;
    logic clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [11:0] wb_adr = 12'h000;
    logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o;
    logic wb_ack_o, dma_write, line_end = 1'b0, vertical_blank = 1'b0, background_output_pin;
    logic background_in = 1'b0, genlock_audio_in = 1'b0, go = 1'b0, last = 1'b0, busy;
    logic [2:0] dma_plane;
    logic [15:0] dma_data;
    logic [7:0] sprite_pixels = 8'h00;
    logic [47:0] words = 48'h0;
    video_pkg::rgb_t rgb_out;
    video_pkg::mode_t mode_out;
    logic [5:0] sprite_priority;
    logic [107:0] plane_pointers;
    int error_cnt = 0, samples_checked = 0;
    integer seed = 32'h9e2d;
    logic [15:0] rq[$], mq[$];
    logic [11:0] pq[$];
    bit pix_on = 1'b0;
    // collision table: control word, sprites shown, flags expected
    logic [15:0] cc[6] = '{16'h0000, 16'h0000, 16'h1000, 16'h0000, 16'h0041, 16'h0000};
    logic [7:0] sp[6] = '{8'h01, 8'h05, 8'h02, 8'h02, 8'h01, 8'h00};
    logic [15:0] cx[6] = '{16'h0023, 16'h0267, 16'h0023, 16'h0001, 16'h0020, 16'h0001};

    always #2.5 clk = ~clk;

    playfield_video_output playfield_video_output_inst (.clk(clk), .rst(rst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .dma_write(dma_write), .dma_plane(dma_plane), .dma_data(dma_data),
        .line_end(line_end), .vertical_blank(vertical_blank), .sprite_pixels(sprite_pixels),
        .background_in(background_in), .genlock_audio_in(genlock_audio_in),
        .rgb_out(rgb_out), .background_output_pin(background_output_pin),
        .mode_out(mode_out), .sprite_priority(sprite_priority),
        .plane_pointers(plane_pointers));
    plane_fetch_model plane_fetch_model_inst (.clk(clk), .go(go), .last(last),
        .words(words), .dma_write(dma_write), .dma_plane(dma_plane),
        .dma_data(dma_data), .busy(busy));

    // ==========================================
    // closing and bus tasks
    task automatic give_verdict;
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic timeout_hit;
        error_cnt++;
        give_verdict();
    endtask
    // classic single cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [11:0] adr, input logic [15:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) timeout_hit();
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] adr, input logic [15:0] e, input logic [15:0] m);
        rq.push_back(e);
        mq.push_back(m);
        wb(1'b0, adr, 16'h0000);
    endtask
    function automatic logic [11:0] pal(input int k);
        return (k < 4) ? 12'(k * 12'h111) : (12'h800 | 12'(k));
    endfunction

    // ==========================================
    // watchers: oldest note against each result
    always @(posedge clk) begin : bus_watch
        logic [31:0] e, m;
        if (wb_cyc && !wb_we && wb_ack_o === 1'b1 && rq.size() > 0) begin
            e = {16'h0000, rq.pop_front()};
            m = {16'hffff, mq.pop_front()};
            `CHK(wb_dat_o & m, e)
        end
    end
    // a group starts on its first non-black pixel, then runs on every clock
    always @(posedge clk) begin : pix_watch
        logic [11:0] e;
        if (pq.size() > 0 && (pix_on || rgb_out !== 12'h000)) begin
            pix_on = pq.size() > 1;
            e = pq.pop_front();
            `CHK(rgb_out, e)
        end
    end

    // ==========================================
    // main sequence
    initial begin : main
        logic [15:0] a, b, r;
        logic [17:0] p1;
        int n;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(mode_out, 8'h00)
        wb(1'b1, 12'h400, 16'h0f0e);
        @(posedge clk);
        `CHK(mode_out, 8'h7f)
        wb(1'b1, 12'h400, 16'ha100);
        @(posedge clk);
        `CHK(mode_out, 8'h90)
        // genlock audio replaces background only in vertical blank
        for (int i = 0; i < 4; i++) begin
            vertical_blank <= i[1];
            genlock_audio_in <= i[0];
            background_in <= ~i[0];
            repeat (3) @(posedge clk);
            // outside blank the pin also marks colour zero, which is all that shows here
            `CHK(background_output_pin, i[1] ? i[0] : 1'b1)
        end
        r = 16'($random(seed)) | 16'h0040;
        wb(1'b1, 12'h410, r);
        @(posedge clk);
        `CHK(sprite_priority, r[5:0])
        wb(1'b1, 12'h408, 16'h0000);
        // pointers reloaded while blanked, then stepped by line end
        vertical_blank <= 1'b1;
        wb(1'b1, 12'h380, 16'h0005);
        wb(1'b1, 12'h388, 16'h1234);
        wb(1'b1, 12'h390, 16'h0001);
        wb(1'b1, 12'h398, 16'h0100);
        vertical_blank <= 1'b0;
        wb(1'b1, 12'h420, 16'h0010);
        wb(1'b1, 12'h428, 16'hfffe);
        `CHK(plane_pointers[17:0], {3'h5, 15'h091a})
        p1 = plane_pointers[17:0];
        line_end <= 1'b1;
        @(posedge clk);
        line_end <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(plane_pointers[35:18], {3'h1, 15'h007e})
        `CHK(plane_pointers[17:0], p1 + 18'h00010)
        for (int k = 0; k < 10; k++) wb(1'b1, 12'h600 + 12'(8 * k), {4'hf, pal(k)});
        wb(1'b1, 12'h400, 16'ha000);
        // groups: plane one by bus, all by fetch, then bus in dual playfield
        // with playfield two in front; plane three is beyond the count
        for (int g = 0; g < 3; g++) begin
            if (g == 2) wb(1'b1, 12'h400, 16'ha400);
            a = (16'($random(seed)) | 16'h8000) & 16'hfffe;
            b = 16'($random(seed)) & 16'hfffe;
            for (int i = 15; i >= 0; i--)
                pq.push_back(g == 2 ? pal(b[i] ? 9 : a[i]) : pal({b[i], a[i]}));
            words <= {16'hffff, b, a};
            last <= g[0];
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while ((busy !== 1'b0 || pq.size() > 0) && n < 80 && !(!g[0] && busy === 1'b0));
            if (!g[0]) wb(1'b1, 12'h440, a);
            n = 0;
            while (pq.size() > 0 && n < 80) begin
                @(posedge clk);
                n++;
            end
            if (pq.size() > 0) timeout_hit();
        end
        // collisions: control, flush read, sprites, read and clear
        for (int t = 0; t < 6; t++) begin
            wb(1'b1, 12'h260, cc[t]);
            rd(12'h038, 16'h0000, 16'h0000);
            sprite_pixels <= sp[t];
            repeat (4) @(posedge clk);
            sprite_pixels <= 8'h00;
            repeat (3) @(posedge clk);
            rd(12'h038, cx[t], 16'hffff);
        end
        rd(12'hffc, 16'h0000, 16'hffff);
        give_verdict();
    end
endmodule
